/* rtl/l2cp_pkg.sv */
// Shared constants and types for the level 2 coherence and prefetch controller.
// Assumes a block address (byte address without the in-block offset) on every request, snoop and memory port.
package l2cp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int ADDR_W = 27;
    localparam int REG_AW = 4;
    localparam int RATIO_W = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam logic [REG_AW-1:0] OFF_CTRL   = 4'h0;
    localparam logic [REG_AW-1:0] OFF_RATIO  = 4'h4;
    localparam logic [REG_AW-1:0] OFF_STATUS = 4'h8;
    localparam logic [REG_AW-1:0] OFF_PFADDR = 4'hC;

    // Field positions
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_PFEN_BIT  = 1;
    localparam int STAT_PEND_BIT  = 0;
    localparam int STAT_TOUCH_BIT = 1;

    // Reset values
    localparam logic               CTRL_EN_RST   = 1'h0;
    localparam logic               CTRL_PFEN_RST = 1'h0;
    localparam logic [RATIO_W-1:0] RATIO_RST     = 4'h0;

    // Least core-to-bus clock ratio at which prefetching may run
    localparam logic [RATIO_W-1:0] MIN_PF_RATIO = 4'h6;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        MESI_I,
        MESI_E,
        MESI_S,
        MESI_M
    } l2cp_mesi_t;

    typedef enum logic [2:0] {
        OP_LOAD,
        OP_STORE,
        OP_FLUSH,
        OP_CLEAN,
        OP_INVAL,
        OP_TOUCH
    } l2cp_cpu_op_t;

    typedef enum logic [2:0] {
        SN_READ,
        SN_RWITM,
        SN_FLUSH,
        SN_CLEAN,
        SN_INVAL
    } l2cp_snoop_op_t;

    typedef struct packed {
        l2cp_cpu_op_t      op;
        logic [ADDR_W-1:0] addr;
        logic              guarded;
    } l2cp_cpu_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              guarded;
    } l2cp_fetch_t;

    typedef struct packed {
        l2cp_snoop_op_t    op;
        logic [ADDR_W-1:0] addr;
    } l2cp_snoop_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              prefetch;
        logic              touch;
        logic              to_l1;
    } l2cp_mem_req_t;

endpackage

/* rtl/l2cp_ctrl.sv */
// Level 2 block state controller: MESI record per block, snoop handling,
// next-block prefetch engine and touch holding register.
// Assumes all inputs synchronous to clk; one access reaches the tag array per cycle.
`timescale 1ns/1ns
`default_nettype none

module l2cp_ctrl #(
    parameter int IDX_W  = 4,
    parameter int PAGE_W = 7
) (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    // Register port
    input  wire logic [l2cp_pkg::REG_AW-1:0]    reg_addr,
    input  wire logic [31:0]                    reg_wdata,
    input  wire logic                           reg_we,
    input  wire logic                           reg_re,
    output logic      [31:0]                    reg_rdata,
    // Data-side requests
    input  wire logic                           data_valid,
    input  wire l2cp_pkg::l2cp_cpu_req_t        data_req,
    output logic                                data_ready,
    // Instruction-side fetch misses
    input  wire logic                           instr_valid,
    input  wire l2cp_pkg::l2cp_fetch_t          instr_req,
    output logic                                instr_ready,
    // Shared response for the allocating read in the same cycle
    input  wire logic                           other_holds,
    // Snooped bus operations
    input  wire logic                           snoop_valid,
    input  wire l2cp_pkg::l2cp_snoop_t          snoop_req,
    // Translation invalidate pulse
    input  wire logic                           tlb_inval,
    // Memory side
    output logic                                fill_valid,
    output l2cp_pkg::l2cp_mem_req_t             fill_req,
    output logic                                wb_valid,
    output logic      [l2cp_pkg::ADDR_W-1:0]    wb_addr
);

    localparam int AW  = l2cp_pkg::ADDR_W;
    localparam int TW  = AW - IDX_W;
    localparam int NUM = 1 << IDX_W;

    if (IDX_W < 1 || IDX_W > 12 || PAGE_W < 1 || PAGE_W >= AW || IDX_W >= AW) begin : g_chk
        $error("l2cp_ctrl: unsupported IDX_W or PAGE_W");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State

    l2cp_pkg::l2cp_mesi_t             st_q [NUM];
    logic [TW-1:0]                    tag_q [NUM];
    logic                             en_q;
    logic                             pf_en_q;
    logic [l2cp_pkg::RATIO_W-1:0]     ratio_q;
    logic                             pf_pend_q;
    logic                             pf_touch_q;
    logic [AW-1:0]                    pf_addr_q;
    logic                             pf_pend_d;
    logic                             pf_touch_d;
    logic [AW-1:0]                    pf_addr_d;
    logic [31:0]                      rdata_q;
    logic                             fill_valid_q;
    l2cp_pkg::l2cp_mem_req_t          fill_q;
    logic                             wb_valid_q;
    logic [AW-1:0]                    wb_addr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Arbitration

    wire is_touch  = data_req.op == l2cp_pkg::OP_TOUCH;
    wire demand    = data_valid && !is_touch;
    wire do_snoop  = snoop_valid && en_q;
    wire do_data   = demand && !do_snoop;
    wire do_instr  = instr_valid && !do_snoop && !demand;
    wire do_pf     = pf_pend_q && !do_snoop && !demand && !instr_valid;
    assign data_ready  = !do_snoop;
    assign instr_ready = !do_snoop && !demand;

    wire [AW-1:0] acc_addr = do_snoop ? snoop_req.addr :
                             do_data  ? data_req.addr  :
                             do_instr ? instr_req.addr : pf_addr_q;
    wire acc_guard = do_data ? data_req.guarded : (do_instr ? instr_req.guarded : 1'b0);

    wire [IDX_W-1:0]          idx    = acc_addr[IDX_W-1:0];
    wire [TW-1:0]             tag    = acc_addr[AW-1:IDX_W];
    wire l2cp_pkg::l2cp_mesi_t cur   = st_q[idx];
    wire                      hit    = en_q && (cur != l2cp_pkg::MESI_I) && (tag_q[idx] == tag);
    wire [AW-1:0]             victim = {tag_q[idx], idx};
    wire                      cur_mod = cur == l2cp_pkg::MESI_M;
    wire                      ratio_ok = ratio_q >= l2cp_pkg::MIN_PF_RATIO;

    ////////////////////////////////////////////////////////////////////////////////
    // Transition decode

    l2cp_pkg::l2cp_mesi_t nxt_st;
    logic                 upd;
    logic                 wb;
    logic                 fill;
    logic                 fill_l1;
    logic                 miss_done;

    always_comb begin
        nxt_st    = cur;
        upd       = 1'b0;
        wb        = 1'b0;
        fill      = 1'b0;
        fill_l1   = 1'b0;
        miss_done = 1'b0;
        if (do_snoop) begin
            if (hit) begin
                case (snoop_req.op)
                    l2cp_pkg::SN_READ: begin
                        if (cur == l2cp_pkg::MESI_E) begin
                            nxt_st = l2cp_pkg::MESI_S;
                            upd    = 1'b1;
                        end
                    end
                    l2cp_pkg::SN_RWITM, l2cp_pkg::SN_FLUSH: begin
                        nxt_st = l2cp_pkg::MESI_I;
                        upd    = 1'b1;
                        wb     = cur_mod;
                    end
                    l2cp_pkg::SN_CLEAN: begin
                        if (cur_mod) begin
                            nxt_st = l2cp_pkg::MESI_E;
                            upd    = 1'b1;
                            wb     = 1'b1;
                        end
                    end
                    l2cp_pkg::SN_INVAL: begin
                        nxt_st = l2cp_pkg::MESI_I;
                        upd    = 1'b1;
                    end
                    default: begin
                        upd = 1'b0;
                    end
                endcase
            end
        end else if (do_data) begin
            case (data_req.op)
                l2cp_pkg::OP_STORE: begin
                    if (hit) begin
                        nxt_st = l2cp_pkg::MESI_M;
                        upd    = !cur_mod;
                    end else begin
                        nxt_st    = l2cp_pkg::MESI_M;
                        upd       = 1'b1;
                        wb        = cur_mod;
                        fill      = 1'b1;
                        fill_l1   = 1'b1;
                        miss_done = 1'b1;
                    end
                end
                l2cp_pkg::OP_FLUSH: begin
                    if (hit) begin
                        nxt_st = l2cp_pkg::MESI_I;
                        upd    = 1'b1;
                        wb     = cur_mod;
                    end
                end
                l2cp_pkg::OP_CLEAN: begin
                    if (hit && cur_mod) begin
                        nxt_st = l2cp_pkg::MESI_E;
                        upd    = 1'b1;
                        wb     = 1'b1;
                    end
                end
                l2cp_pkg::OP_INVAL: begin
                    if (hit) begin
                        nxt_st = l2cp_pkg::MESI_I;
                        upd    = 1'b1;
                    end
                end
                default: begin
                    if (!hit) begin
                        nxt_st    = other_holds ? l2cp_pkg::MESI_S : l2cp_pkg::MESI_E;
                        upd       = 1'b1;
                        wb        = cur_mod;
                        fill      = 1'b1;
                        fill_l1   = 1'b1;
                        miss_done = 1'b1;
                    end
                end
            endcase
        end else if ((do_instr || do_pf) && !hit) begin
            nxt_st    = other_holds ? l2cp_pkg::MESI_S : l2cp_pkg::MESI_E;
            upd       = 1'b1;
            wb        = cur_mod;
            fill      = 1'b1;
            // prefetched and touched blocks stay out of level 1
            fill_l1   = do_instr;
            miss_done = 1'b1;
        end
        if (!en_q) begin
            upd = 1'b0;
            wb  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Prefetch engine

    wire ctrl_wr    = reg_we && reg_addr == l2cp_pkg::OFF_CTRL;
    wire last_line  = &acc_addr[PAGE_W-1:0];
    wire launch     = en_q && pf_en_q && ratio_ok && miss_done && !acc_guard && !last_line
                      && !(do_pf && pf_touch_q);
    // touch taken regardless of prefetch enable
    wire touch_take = data_valid && is_touch && data_ready && en_q && ratio_ok
                      && !data_req.guarded;
    wire pf_kill    = ctrl_wr || tlb_inval || !ratio_ok || !en_q;

    always_comb begin
        pf_pend_d  = pf_pend_q;
        pf_touch_d = pf_touch_q;
        pf_addr_d  = pf_addr_q;
        if (pf_kill) begin
            pf_pend_d = 1'b0;
        end else if (touch_take) begin
            pf_pend_d  = 1'b1;
            pf_touch_d = 1'b1;
            pf_addr_d  = data_req.addr;
        end else if (launch) begin
            pf_pend_d  = 1'b1;
            pf_touch_d = 1'b0;
            pf_addr_d  = acc_addr + AW'(1);
        end else if (do_data || do_pf) begin
            // demand drops pending prefetch, hit ends the sequence
            pf_pend_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM; i++) begin
                st_q[i]  <= l2cp_pkg::MESI_I;
                tag_q[i] <= '0;
            end
        end else if (upd) begin
            st_q[idx]  <= nxt_st;
            tag_q[idx] <= tag;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pf_pend_q  <= 1'b0;
            pf_touch_q <= 1'b0;
            pf_addr_q  <= '0;
        end else begin
            pf_pend_q  <= pf_pend_d;
            pf_touch_q <= pf_touch_d;
            pf_addr_q  <= pf_addr_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fill_valid_q <= 1'b0;
            fill_q       <= '0;
            wb_valid_q   <= 1'b0;
            wb_addr_q    <= '0;
        end else begin
            fill_valid_q <= fill;
            fill_q       <= '{addr: acc_addr, prefetch: do_pf, touch: do_pf && pf_touch_q,
                              to_l1: fill_l1};
            wb_valid_q   <= wb;
            wb_addr_q    <= victim;
        end
    end

    assign fill_valid = fill_valid_q;
    assign fill_req   = fill_q;
    assign wb_valid   = wb_valid_q;
    assign wb_addr    = wb_addr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Register port

    wire ratio_wr = reg_we && reg_addr == l2cp_pkg::OFF_RATIO;
    wire [31:0] rd_mux =
        (reg_addr == l2cp_pkg::OFF_CTRL)   ? 32'({pf_en_q, en_q}) :
        (reg_addr == l2cp_pkg::OFF_RATIO)  ? 32'(ratio_q) :
        (reg_addr == l2cp_pkg::OFF_STATUS) ? 32'({pf_touch_q, pf_pend_q}) :
        (reg_addr == l2cp_pkg::OFF_PFADDR) ? 32'(pf_addr_q) : 32'h0000_0000;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q    <= l2cp_pkg::CTRL_EN_RST;
            pf_en_q <= l2cp_pkg::CTRL_PFEN_RST;
            ratio_q <= l2cp_pkg::RATIO_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            if (ctrl_wr) begin
                en_q    <= reg_wdata[l2cp_pkg::CTRL_EN_BIT];
                pf_en_q <= reg_wdata[l2cp_pkg::CTRL_PFEN_BIT];
            end
            if (ratio_wr) begin
                ratio_q <= reg_wdata[l2cp_pkg::RATIO_W-1:0];
            end
            rdata_q <= reg_re ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire ld_miss = do_data && data_req.op == l2cp_pkg::OP_LOAD && !hit && en_q;
    wire st_miss = do_data && data_req.op == l2cp_pkg::OP_STORE && !hit && en_q;

    sequence s_clean_hit;
        do_data && data_req.op == l2cp_pkg::OP_CLEAN && hit && cur_mod;
    endsequence
    sequence s_clean_done;
        wb_valid && st_q[$past(idx)] == l2cp_pkg::MESI_E;
    endsequence

    property p_read_alloc;
        ld_miss |=> st_q[$past(idx)] == ($past(other_holds) ? l2cp_pkg::MESI_S : l2cp_pkg::MESI_E);
    endproperty
    a_read_alloc: assert property (p_read_alloc) else $error("read miss state wrong");

    property p_write_alloc;
        st_miss |=> st_q[$past(idx)] == l2cp_pkg::MESI_M && fill_valid && fill_req.to_l1;
    endproperty
    a_write_alloc: assert property (p_write_alloc) else $error("write miss state wrong");

    property p_evict_wb;
        (ld_miss || st_miss) && cur_mod |=> wb_valid && wb_addr == $past(victim);
    endproperty
    a_evict_wb: assert property (p_evict_wb) else $error("modified victim not written");

    property p_store_hit;
        do_data && data_req.op == l2cp_pkg::OP_STORE && hit |=> st_q[$past(idx)] == l2cp_pkg::MESI_M;
    endproperty
    a_store_hit: assert property (p_store_hit) else $error("store hit not modified");

    property p_snoop_read;
        do_snoop && snoop_req.op == l2cp_pkg::SN_READ && hit && cur == l2cp_pkg::MESI_E
            |=> st_q[$past(idx)] == l2cp_pkg::MESI_S;
    endproperty
    a_snoop_read: assert property (p_snoop_read) else $error("snoop read no downgrade");

    property p_clean;
        s_clean_hit |=> s_clean_done;
    endproperty
    a_clean: assert property (p_clean) else $error("clean failed");

    property p_inval;
        do_snoop && snoop_req.op == l2cp_pkg::SN_INVAL && hit
            |=> !wb_valid && st_q[$past(idx)] == l2cp_pkg::MESI_I;
    endproperty
    a_inval: assert property (p_inval) else $error("invalidate wrong");

    property p_disabled;
        !en_q && snoop_valid |=> !wb_valid && st_q[$past(idx)] == $past(cur);
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled cache changed");

    property p_ratio;
        !ratio_ok |=> !pf_pend_q ##1 !fill_req.prefetch || !fill_valid;
    endproperty
    a_ratio: assert property (p_ratio) else $error("prefetch at low ratio");

    property p_drop;
        pf_pend_q && do_data && !launch |=> !pf_pend_q;
    endproperty
    a_drop: assert property (p_drop) else $error("prefetch not dropped");

    property p_touch_l2;
        do_pf && pf_touch_q && !hit |=> fill_valid && fill_req.touch && !fill_req.to_l1
            ##1 !(pf_pend_q && !pf_touch_q && !$past(launch));
    endproperty
    a_touch_l2: assert property (p_touch_l2) else $error("touch fill wrong");

endmodule

`default_nettype wire

/* sim/l2cp_far_cpu.sv */
// Model of another processor on the shared bus: snoops and shared response.
// Assumes the bench calls its tasks between clock edges of clk.
`timescale 1ns/1ns
`default_nettype none
module l2cp_far_cpu (
    // Clock
    input  wire logic                    clk,
    // Observed local request
    input  wire logic                    data_valid,
    input  wire l2cp_pkg::l2cp_cpu_req_t data_req,
    // Bus side
    output logic                         other_holds,
    output logic                         snoop_valid,
    output l2cp_pkg::l2cp_snoop_t        snoop_req
);
    logic [l2cp_pkg::ADDR_W-1:0] held;
    assign other_holds = data_valid && (data_req.addr == held);
    initial begin
        held = '1;
        snoop_valid = 1'b0;
        snoop_req = '0;
    end
    task automatic own(input logic [26:0] a);
        held = a;
    endtask
    // Released lines show the inverse so stale values never match
    task automatic snoop(input l2cp_pkg::l2cp_snoop_op_t op, input logic [26:0] a);
        @(posedge clk);
        snoop_valid <= 1'b1;
        snoop_req <= {op, a};
        @(posedge clk);
        snoop_valid <= 1'b0;
        snoop_req <= ~{op, a};
    endtask
endmodule
`default_nettype wire

/* sim/test_l2cp_ctrl.sv */
// Self-checking bench for the level 2 coherence and prefetch controller.
// Assumes the package and controller are compiled first; instruction side idle except in t_instr.
`timescale 1ns/1ns
`default_nettype none
module test_l2cp_ctrl;
    logic                      clk, rst_n, reg_we, reg_re, data_valid, data_ready;
    logic                      instr_ready, tlb_inval, fill_valid, wb_valid, instr_valid;
    l2cp_pkg::l2cp_fetch_t     instr_req;
    logic                      other_holds, snoop_valid, f, w;
    logic [3:0]                reg_addr;
    logic [31:0]               reg_wdata, reg_rdata, v;
    logic [26:0]               wb_addr;
    l2cp_pkg::l2cp_cpu_req_t   data_req;
    l2cp_pkg::l2cp_snoop_t     snoop_req;
    l2cp_pkg::l2cp_mem_req_t   fill_req, pr;
    int                        err_count, checked, n;

    l2cp_ctrl uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .data_valid(data_valid),
        .data_req(data_req), .data_ready(data_ready), .instr_valid(instr_valid),
        .instr_req(instr_req), .instr_ready(instr_ready), .other_holds(other_holds),
        .snoop_valid(snoop_valid), .snoop_req(snoop_req), .tlb_inval(tlb_inval),
        .fill_valid(fill_valid), .fill_req(fill_req), .wb_valid(wb_valid), .wb_addr(wb_addr));
    l2cp_far_cpu far (.clk(clk), .data_valid(data_valid), .data_req(data_req),
        .other_holds(other_holds), .snoop_valid(snoop_valid), .snoop_req(snoop_req));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Two requests back to back, then the cycle after the second is taken
    task automatic two(input l2cp_pkg::l2cp_cpu_op_t o1, input logic [26:0] a1,
                       input l2cp_pkg::l2cp_cpu_op_t o2, input logic [26:0] a2);
        @(posedge clk);
        data_valid <= 1'b1;
        data_req <= {o1, a1, 1'b0};
        @(posedge clk);
        data_req <= {o2, a2, 1'b0};
        @(posedge clk);
        data_valid <= 1'b0;
        data_req <= ~{o2, a2, 1'b0};
        #1;
    endtask
    task automatic acc(input l2cp_pkg::l2cp_cpu_op_t op, input logic [26:0] a,
                       input logic g = 1'b0);
        @(posedge clk);
        data_valid <= 1'b1;
        data_req <= {op, a, g};
        @(posedge clk);
        data_valid <= 1'b0;
        data_req <= ~{op, a, g};
        #1;
        f = fill_valid;
        w = wb_valid;
    endtask
    task automatic watch(input int c);
        n = 0;
        repeat (c) begin
            @(posedge clk);
            #1;
            if (fill_valid === 1'b1) begin
                if (n == 0) pr = fill_req;
                n++;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(l2cp_pkg::OFF_CTRL);
        chk("ctrl reset", v, 32'h0000_0000);
        rd(l2cp_pkg::OFF_RATIO);
        chk("ratio reset", v, 32'h0000_0000);
        rd(l2cp_pkg::OFF_STATUS);
        chk("status reset", v, 32'h0000_0000);
        rd(4'h2);
        chk("unmapped", v, 32'h0000_0000);
        wr(l2cp_pkg::OFF_CTRL, 32'h0000_0003);
        rd(l2cp_pkg::OFF_CTRL);
        chk("ctrl back", v, 32'h0000_0003);
        wr(l2cp_pkg::OFF_CTRL, 32'h0000_0001);
    endtask
    task automatic t_mesi;
        acc(l2cp_pkg::OP_LOAD, 27'h000_0020);
        chk("load miss", 32'(f), 32'h0000_0001);
        acc(l2cp_pkg::OP_STORE, 27'h000_0020);
        chk("store hit", 32'(f), 32'h0000_0000);
        acc(l2cp_pkg::OP_FLUSH, 27'h000_0020);
        chk("flush wb", 32'(w), 32'h0000_0001);
        acc(l2cp_pkg::OP_LOAD, 27'h000_0020);
        chk("flushed miss", 32'(f), 32'h0000_0001);
        acc(l2cp_pkg::OP_STORE, 27'h000_0021);
        chk("write miss", 32'(f), 32'h0000_0001);
        acc(l2cp_pkg::OP_CLEAN, 27'h000_0021);
        chk("clean wb", 32'(w), 32'h0000_0001);
        acc(l2cp_pkg::OP_CLEAN, 27'h000_0021);
        chk("clean again", 32'(w), 32'h0000_0000);
        acc(l2cp_pkg::OP_STORE, 27'h000_0021);
        acc(l2cp_pkg::OP_INVAL, 27'h000_0021);
        chk("inval no wb", 32'(w), 32'h0000_0000);
        acc(l2cp_pkg::OP_LOAD, 27'h000_0021);
        chk("inval miss", 32'(f), 32'h0000_0001);
        acc(l2cp_pkg::OP_STORE, 27'h000_0020);
        acc(l2cp_pkg::OP_LOAD, 27'h000_0030);
        chk("evict wb", 32'(w), 32'h0000_0001);
        chk("evict addr", 32'(wb_addr), 32'h0000_0020);
        far.own(27'h000_0045);
        acc(l2cp_pkg::OP_LOAD, 27'h000_0045);
        far.own('1);
        acc(l2cp_pkg::OP_STORE, 27'h000_0045);
        chk("shared hit", 32'(f), 32'h0000_0000);
        far.snoop(l2cp_pkg::SN_RWITM, 27'h000_0045);
        acc(l2cp_pkg::OP_LOAD, 27'h000_0045);
        chk("rwitm miss", 32'(f), 32'h0000_0001);
        acc(l2cp_pkg::OP_LOAD, 27'h000_0046);
        far.snoop(l2cp_pkg::SN_READ, 27'h000_0046);
        acc(l2cp_pkg::OP_LOAD, 27'h000_0046);
        chk("snoop read hit", 32'(f), 32'h0000_0000);
    endtask
    task automatic t_off;
        acc(l2cp_pkg::OP_STORE, 27'h000_0048);
        wr(l2cp_pkg::OFF_CTRL, 32'h0000_0000);
        far.snoop(l2cp_pkg::SN_INVAL, 27'h000_0048);
        acc(l2cp_pkg::OP_LOAD, 27'h000_0058);
        chk("off no evict", 32'(w), 32'h0000_0000);
        wr(l2cp_pkg::OFF_CTRL, 32'h0000_0001);
        acc(l2cp_pkg::OP_FLUSH, 27'h000_0048);
        chk("snoop ignored", 32'(w), 32'h0000_0001);
    endtask
    task automatic t_pf;
        wr(l2cp_pkg::OFF_RATIO, 32'h0000_0006);
        wr(l2cp_pkg::OFF_CTRL, 32'h0000_0003);
        acc(l2cp_pkg::OP_LOAD, 27'h000_0100);
        watch(3);
        chk("pf count", 32'(n), 32'h0000_0003);
        chk("pf addr", 32'(pr.addr), 32'h0000_0101);
        chk("pf flag", 32'({pr.prefetch, pr.to_l1}), 32'h0000_0002);
        wr(l2cp_pkg::OFF_CTRL, 32'h0000_0003);
        watch(2);
        watch(8);
        chk("ctrl stop", 32'(n), 32'h0000_0000);
        rd(l2cp_pkg::OFF_STATUS);
        chk("stop status", v, 32'h0000_0000);
        rd(l2cp_pkg::OFF_PFADDR);
        chk("stop addr", v, 32'h0000_0105);
        acc(l2cp_pkg::OP_LOAD, 27'h000_017F);
        watch(4);
        chk("page end", 32'(n), 32'h0000_0000);
        acc(l2cp_pkg::OP_LOAD, 27'h000_0200, 1'b1);
        watch(4);
        chk("guarded", 32'(n), 32'h0000_0000);
        two(l2cp_pkg::OP_LOAD, 27'h000_0300, l2cp_pkg::OP_LOAD, 27'h000_0400);
        watch(3);
        chk("drop pf", 32'(pr.addr), 32'h0000_0401);
        @(posedge clk);
        tlb_inval <= 1'b1;
        @(posedge clk);
        tlb_inval <= 1'b0;
        watch(2);
        watch(8);
        chk("tlb stop", 32'(n), 32'h0000_0000);
        wr(l2cp_pkg::OFF_RATIO, 32'h0000_0005);
        acc(l2cp_pkg::OP_LOAD, 27'h000_0500);
        watch(4);
        chk("low ratio", 32'(n), 32'h0000_0000);
        wr(l2cp_pkg::OFF_RATIO, 32'h0000_0006);
        wr(l2cp_pkg::OFF_CTRL, 32'h0000_0001);
        acc(l2cp_pkg::OP_LOAD, 27'h000_0800);
        watch(4);
        chk("pf gated", 32'(n), 32'h0000_0000);
        two(l2cp_pkg::OP_TOUCH, 27'h000_0600, l2cp_pkg::OP_TOUCH, 27'h000_0700);
        watch(8);
        chk("touch count", 32'(n), 32'h0000_0001);
        chk("touch addr", 32'(pr.addr), 32'h0000_0700);
        chk("touch flag", 32'({pr.touch, pr.to_l1}), 32'h0000_0002);
    endtask
    // Demand and instruction miss together: instruction side waits one cycle
    task automatic t_instr;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_req <= {27'h000_0900, 1'b0};
        data_valid <= 1'b1;
        data_req <= {l2cp_pkg::OP_LOAD, 27'h000_0A00, 1'b0};
        #1;
        chk("instr held", 32'({data_ready, instr_ready}), 32'h0000_0002);
        @(posedge clk);
        data_valid <= 1'b0;
        #1;
        chk("instr free", 32'(instr_ready), 32'h0000_0001);
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk("instr fill", 32'({fill_req.addr, fill_req.to_l1}), 32'h0000_1201);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        err_count++;
        test_done();
    end
    initial begin
        {rst_n, reg_we, reg_re, data_valid, tlb_inval, instr_valid} = '0;
        {reg_addr, reg_wdata, data_req, instr_req} = '0;
        err_count = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_mesi();
        t_off();
        t_pf();
        t_instr();
        test_done();
    end
endmodule
`default_nettype wire
